// file: inc/crf_pkg.sv
// Shared constants and types for the cryogenic receiver mode controller.
package crf_pkg;

  // Controller states, Gray coded along the usual start-up path.
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_COOL = 3'h1,
    ST_REG = 3'h3,
    ST_VFLT = 3'h2,
    ST_SHUT = 3'h6,
    ST_FORCE = 3'h7
  } crf_state_t;

  // Timing, in the units printed, and derived cycle counts at 40 MHz.
  localparam longint CLK_HZ = 40_000_000;
  localparam longint DWELL_S = 300;
  localparam longint INIT_MS = 100;
  localparam longint RAMP_MS = 10;
  localparam longint DEB_MS = 20;
  localparam longint FLASH_MS = 500;
  localparam longint DWELL_CYC = DWELL_S * CLK_HZ;
  localparam longint INIT_CYC = (INIT_MS * CLK_HZ) / 1000;
  localparam longint RAMP_CYC = (RAMP_MS * CLK_HZ) / 1000;
  localparam longint DEB_CYC = (DEB_MS * CLK_HZ) / 1000;
  localparam longint FLASH_CYC = (FLASH_MS * CLK_HZ) / 1000;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DRIVE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_ST = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;

  // Field positions and reset values.
  localparam int CTRL_AUTO_BIT = 0;
  localparam int DRV_MIN_LSB = 0;
  localparam int DRV_MAX_LSB = 8;
  localparam int DRV_REG_LSB = 16;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic [7:0] DRV_MIN_RST = 8'h20;
  localparam logic [7:0] DRV_MAX_RST = 8'hff;
  localparam logic [7:0] DRV_REG_RST = 8'h80;

  // Interrupt event bit positions.
  localparam int EV_STATE = 0;
  localparam int EV_VFLT = 1;
  localparam int EV_SHUT = 2;
  localparam int EV_BTN = 3;
  localparam int EV_N = 4;

  // Synchronised pin vector positions.
  localparam int IN_RNG = 0;
  localparam int IN_TOL = 1;
  localparam int IN_VFLT = 2;
  localparam int IN_SHUT = 3;
  localparam int IN_BTN = 4;

  // Front-end drive outputs.
  typedef struct packed {
    logic [7:0] motor_drive;
    logic motor_on;
    logic lna_en;
    logic bypass;
    logic red_led;
    logic grn_led;
    logic alarm;
    logic normal_mode;
  } crf_out_t;

endpackage : crf_pkg

// file: rtl/crf_mode_fsm.sv
// Mode controller for a cooled receive front-end with a small register port.
// What this block does
// - After reset enter state 0: minimum motor drive, bypass, both LEDs steady.
// - State 0 advances unconditionally to cooldown state 1 once initialisation ends.
// - Cooldown runs the motor at maximum, keeps bypass and both LEDs steady.
// - In cooldown, enable the amplifiers once narrow-range temperature is in bounds.
// - Go to regulate after 300 s in tolerance with amplifiers on; restart on exit.
// - Regulate holds temperature indefinitely, normal routing, red off, green on.
// - Supply fault enters state 3 with bypass, red on, green off.
// - State 3 keeps regulating the cooler instead of stopping the motor.
// - In automatic operation, supply fault clearing returns state 3 to regulate.
// - State 4 ramps motor drive to zero, then stops it; bypass, red on, green off.
// - Automatic exit from 4 to 0 needs warmed temperature and all faults clear.
// - Forced bypass request enters state 5 with bypass, overriding everything.
// - In state 5 every lit LED flashes, so at least one flashes.
// - Normal mode only in regulate; every other state reports bypass.
// - Bypass relays route around the filter and the low-noise amplifier.
// - Each button press toggles forced bypass; alarm relay active while forced.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
module crf_mode_fsm #(
  parameter logic [35:0] P_DWELL = 36'(crf_pkg::DWELL_CYC),
  parameter logic [23:0] P_INIT = 24'(crf_pkg::INIT_CYC),
  parameter logic [23:0] P_RAMP = 24'(crf_pkg::RAMP_CYC),
  parameter logic [23:0] P_DEB = 24'(crf_pkg::DEB_CYC),
  parameter logic [24:0] P_FLASH = 25'(crf_pkg::FLASH_CYC)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic temp_in_range,
  input wire logic temp_in_tol,
  input wire logic vin_fault,
  input wire logic shut_fault,
  input wire logic bypass_btn_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic irq,
  output crf_pkg::crf_out_t fe
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic btn_st;
    logic [23:0] deb;
    logic [24:0] fl_cnt;
    logic flash;
    crf_pkg::crf_state_t state;
    logic [35:0] dwell;
    logic [23:0] tmr;
    logic red_base;
    logic auto_en;
    logic [7:0] drv_min;
    logic [7:0] drv_max;
    logic [7:0] drv_reg;
    logic [crf_pkg::EV_N-1:0] ev_st;
    logic [crf_pkg::EV_N-1:0] ev_en;
    logic [31:0] rd_data;
    logic irq;
    crf_pkg::crf_out_t fe;
  } crf_st_t;

  crf_st_t st_r;
  crf_st_t st_nxt;

  always_comb
  begin
    logic press;
    logic rng;
    logic tol;
    logic vflt;
    logic sflt;
    logic [crf_pkg::EV_N-1:0] ev;
    crf_pkg::crf_state_t ns;
    press = 1'b0;
    ev = '0;
    st_nxt = st_r;
    rng = st_r.s2[crf_pkg::IN_RNG];
    tol = st_r.s2[crf_pkg::IN_TOL];
    vflt = st_r.s2[crf_pkg::IN_VFLT];
    sflt = st_r.s2[crf_pkg::IN_SHUT];
    // Unless a transition below fires, the state holds.
    ns = st_r.state;

    // Two-stage synchronisers for all pins.
    st_nxt.s1 = {bypass_btn_n, shut_fault, vin_fault, temp_in_tol, temp_in_range};
    st_nxt.s2 = st_r.s1;

    // Debounce: the level must hold for the whole window before it is accepted.
    if (st_r.s2[crf_pkg::IN_BTN] != st_r.btn_st)
    begin
      if (st_r.deb == P_DEB - 24'h1)
      begin
        st_nxt.deb = '0;
        st_nxt.btn_st = st_r.s2[crf_pkg::IN_BTN];
        press = st_r.btn_st;
      end
      else
      begin
        st_nxt.deb = st_r.deb + 24'h1;
      end
    end
    else
    begin
      st_nxt.deb = '0;
    end

    // Free-running slow flash.
    if (st_r.fl_cnt == P_FLASH - 25'h1)
    begin
      st_nxt.fl_cnt = '0;
      st_nxt.flash = ~st_r.flash;
    end
    else
    begin
      st_nxt.fl_cnt = st_r.fl_cnt + 25'h1;
    end

    // State selection; forced bypass outranks shutdown, which outranks supply fault.
    if (press)
    begin
      ev[crf_pkg::EV_BTN] = 1'b1;
      if (st_r.state == crf_pkg::ST_FORCE)
      begin
        ns = crf_pkg::ST_REG;
      end
      else
      begin
        ns = crf_pkg::ST_FORCE;
        st_nxt.red_base = st_r.fe.red_led;
      end
    end
    else if (st_r.state == crf_pkg::ST_FORCE)
    begin
      ns = crf_pkg::ST_FORCE;
    end
    else if (sflt && st_r.state != crf_pkg::ST_SHUT)
    begin
      ns = crf_pkg::ST_SHUT;
    end
    else if (vflt && st_r.state != crf_pkg::ST_SHUT && st_r.state != crf_pkg::ST_VFLT)
    begin
      ns = crf_pkg::ST_VFLT;
    end
    else
    begin
      case (st_r.state)
        crf_pkg::ST_INIT:
        begin
          st_nxt.fe.motor_on = 1'b1;
          st_nxt.fe.motor_drive = st_r.drv_min;
          st_nxt.fe.lna_en = 1'b0;
          st_nxt.tmr = st_r.tmr + 24'h1;
          if (st_r.tmr == P_INIT - 24'h1)
          begin
            ns = crf_pkg::ST_COOL;
          end
        end
        crf_pkg::ST_COOL:
        begin
          st_nxt.fe.motor_on = 1'b1;
          st_nxt.fe.motor_drive = st_r.drv_max;
          if (rng)
          begin
            st_nxt.fe.lna_en = 1'b1;
          end
          // The dwell only runs with the amplifiers already on.
          if (tol && st_r.fe.lna_en)
          begin
            st_nxt.dwell = st_r.dwell + 36'h1;
            if (st_r.dwell == P_DWELL - 36'h1)
            begin
              ns = crf_pkg::ST_REG;
            end
          end
          else
          begin
            st_nxt.dwell = '0;
          end
        end
        crf_pkg::ST_REG:
        begin
          st_nxt.fe.motor_on = 1'b1;
          st_nxt.fe.motor_drive = st_r.drv_reg;
          // Normal routing passes through the amplifiers, so they must be powered.
          st_nxt.fe.lna_en = 1'b1;
        end
        crf_pkg::ST_VFLT:
        begin
          st_nxt.fe.motor_on = 1'b1;
          st_nxt.fe.motor_drive = st_r.drv_reg;
          // Leaving while the supply is still bad would bounce between 2 and 3 every cycle.
          if (st_r.auto_en && !vflt)
          begin
            ns = crf_pkg::ST_REG;
          end
        end
        crf_pkg::ST_SHUT:
        begin
          st_nxt.fe.lna_en = 1'b0;
          if (st_r.fe.motor_drive == 8'h00)
          begin
            st_nxt.fe.motor_on = 1'b0;
          end
          else if (st_r.tmr == P_RAMP - 24'h1)
          begin
            st_nxt.tmr = '0;
            st_nxt.fe.motor_drive = st_r.fe.motor_drive - 8'h01;
          end
          else
          begin
            st_nxt.tmr = st_r.tmr + 24'h1;
          end
          // Restarting while still cold would skip a proper cooldown.
          if (st_r.auto_en && !rng && !sflt && !vflt)
          begin
            ns = crf_pkg::ST_INIT;
          end
        end
        default:
        begin
          ns = crf_pkg::ST_INIT;
        end
      endcase
    end

    if (ns != st_r.state)
    begin
      st_nxt.tmr = '0;
      st_nxt.dwell = '0;
      ev[crf_pkg::EV_STATE] = 1'b1;
      ev[crf_pkg::EV_VFLT] = (ns == crf_pkg::ST_VFLT);
      ev[crf_pkg::EV_SHUT] = (ns == crf_pkg::ST_SHUT);
    end
    st_nxt.state = ns;

    // Indicators and relays follow the next state so they change with it.
    st_nxt.fe.bypass = (ns != crf_pkg::ST_REG);
    st_nxt.fe.normal_mode = (ns == crf_pkg::ST_REG);
    st_nxt.fe.alarm = (ns == crf_pkg::ST_FORCE);
    case (ns)
      crf_pkg::ST_INIT, crf_pkg::ST_COOL:
      begin
        st_nxt.fe.red_led = 1'b1;
        st_nxt.fe.grn_led = 1'b1;
      end
      crf_pkg::ST_REG:
      begin
        st_nxt.fe.red_led = 1'b0;
        st_nxt.fe.grn_led = 1'b1;
      end
      crf_pkg::ST_FORCE:
      begin
        // Green always counts as lit, so one LED flashes whatever the entry state.
        st_nxt.fe.red_led = st_nxt.red_base & st_r.flash;
        st_nxt.fe.grn_led = st_r.flash;
      end
      default:
      begin
        st_nxt.fe.red_led = 1'b1;
        st_nxt.fe.grn_led = 1'b0;
      end
    endcase

    // Register writes.
    if (wr_en)
    begin
      case (addr)
        crf_pkg::REG_CTRL:
        begin
          st_nxt.auto_en = wr_data[crf_pkg::CTRL_AUTO_BIT];
        end
        crf_pkg::REG_DRIVE:
        begin
          st_nxt.drv_min = wr_data[crf_pkg::DRV_MIN_LSB +: 8];
          st_nxt.drv_max = wr_data[crf_pkg::DRV_MAX_LSB +: 8];
          st_nxt.drv_reg = wr_data[crf_pkg::DRV_REG_LSB +: 8];
        end
        crf_pkg::REG_IRQ_EN:
        begin
          st_nxt.ev_en = wr_data[crf_pkg::EV_N-1:0];
        end
        default:
        begin
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (wr_en && addr == crf_pkg::REG_IRQ_CLR)
    begin
      st_nxt.ev_st = (st_r.ev_st & ~wr_data[crf_pkg::EV_N-1:0]) | ev;
    end
    else
    begin
      st_nxt.ev_st = st_r.ev_st | ev;
    end
    st_nxt.irq = |(st_nxt.ev_st & st_nxt.ev_en);

    // Read data stands for exactly one cycle after the strobe.
    st_nxt.rd_data = '0;
    if (rd_en)
    begin
      case (addr)
        crf_pkg::REG_CTRL:
        begin
          st_nxt.rd_data = {31'h0, st_r.auto_en};
        end
        crf_pkg::REG_DRIVE:
        begin
          st_nxt.rd_data = {8'h00, st_r.drv_reg, st_r.drv_max, st_r.drv_min};
        end
        crf_pkg::REG_STATUS:
        begin
          st_nxt.rd_data = {9'h0, st_r.s2, st_r.fe, st_r.state};
        end
        crf_pkg::REG_IRQ_ST:
        begin
          st_nxt.rd_data = {28'h0, st_r.ev_st};
        end
        crf_pkg::REG_IRQ_EN:
        begin
          st_nxt.rd_data = {28'h0, st_r.ev_en};
        end
        default:
        begin
          st_nxt.rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Pins reset to their idle levels, released button and no fault, so no false event follows.
      st_r.s1 <= 5'h10;
      st_r.s2 <= 5'h10;
      st_r.btn_st <= 1'b1;
      st_r.deb <= '0;
      st_r.fl_cnt <= '0;
      st_r.flash <= 1'b0;
      st_r.state <= crf_pkg::ST_INIT;
      st_r.dwell <= '0;
      st_r.tmr <= '0;
      st_r.red_base <= 1'b0;
      st_r.auto_en <= crf_pkg::CTRL_AUTO_RST;
      st_r.drv_min <= crf_pkg::DRV_MIN_RST;
      st_r.drv_max <= crf_pkg::DRV_MAX_RST;
      st_r.drv_reg <= crf_pkg::DRV_REG_RST;
      st_r.ev_st <= '0;
      st_r.ev_en <= '0;
      st_r.rd_data <= '0;
      st_r.irq <= 1'b0;
      st_r.fe.motor_drive <= 8'h00;
      st_r.fe.motor_on <= 1'b0;
      st_r.fe.lna_en <= 1'b0;
      st_r.fe.bypass <= 1'b1;
      st_r.fe.red_led <= 1'b1;
      st_r.fe.grn_led <= 1'b1;
      st_r.fe.alarm <= 1'b0;
      st_r.fe.normal_mode <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign irq = st_r.irq;
  assign fe = st_r.fe;

endmodule : crf_mode_fsm

// file: dv/crf_mode_chk_asserts.sv
// Port-level checker for the receiver mode controller.
module crf_mode_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vin_fault,
  input wire logic shut_fault,
  input wire crf_pkg::crf_out_t fe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  norm_route_a: assert property (fe.normal_mode |-> !fe.bypass && !fe.red_led && fe.grn_led)
    else $error("normal mode with wrong relays or LEDs");
  mode_flag_a: assert property (fe.bypass != fe.normal_mode)
    else $error("mode flag disagrees with bypass");
  red_bypass_a: assert property (fe.bypass && !fe.alarm |-> fe.red_led)
    else $error("bypass without red LED");
  alarm_force_a: assert property (fe.alarm |-> fe.bypass && !fe.normal_mode)
    else $error("alarm outside forced bypass");
  vin_enter_a: assert property (vin_fault && !shut_fault && !fe.alarm |->
    ##[1:4] (fe.bypass && !fe.grn_led))
    else $error("supply fault not entered");
  shut_enter_a: assert property (shut_fault && !fe.alarm |->
    ##[1:4] (!fe.grn_led && !fe.lna_en))
    else $error("shutdown fault not entered");
  motor_stop_a: assert property ($fell(fe.motor_on) |-> $past(fe.motor_drive) == 8'h00)
    else $error("motor stopped before drive reached zero");
  motor_off_a: assert property (!fe.motor_on |-> fe.motor_drive == 8'h00)
    else $error("drive while motor off");
  // The green LED in forced bypass may never stay on for more than nine cycles in a row.
  flash_run_a: assert property ((fe.alarm && fe.grn_led) [*8] |->
    ##[1:2] !(fe.alarm && fe.grn_led))
    else $error("green LED steady in forced bypass");
endmodule : crf_mode_chk
bind crf_mode_fsm crf_mode_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .vin_fault(vin_fault),
  .shut_fault(shut_fault),
  .fe(fe)
);

// file: dv/crf_fe_model.sv
// Behavioural model of the sensors, supply monitors and front-panel button.
module crf_fe_model (
  input wire logic clk,
  input wire logic cold,
  input wire logic tol_ok,
  input wire logic vflt,
  input wire logic shut,
  input wire logic press,
  output logic temp_in_range,
  output logic temp_in_tol,
  output logic vin_fault,
  output logic shut_fault,
  output logic bypass_btn_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r = 5'h0;
  // Tolerance only means something while the sensor reads inside its range.
  assign temp_in_range = cold;
  assign temp_in_tol = cold && tol_ok;
  assign vin_fault = vflt;
  assign shut_fault = shut;
  // Two one-cycle contact bounces come before the steady hold, as real switches do.
  always @(posedge clk)
  begin
    if (press)
      cnt_r <= 5'h14;
    else if (cnt_r != 5'h0)
      cnt_r <= cnt_r - 5'h1;
  end
  assign bypass_btn_n = !(cnt_r inside {[5'h1:5'hc], 5'h10, 5'h12});
endmodule : crf_fe_model

// file: dv/tb_crf_mode_fsm.sv
// Self-checking bench for the mode controller and its front-end model.
module tb_crf_mode_fsm;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cold = 1'b0, tol_ok = 1'b0, vflt = 1'b0, shut = 1'b0, press = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, rv = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [7:0] rnd;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic rng, tol, vin, sht, btn_n, irq, g;
  crf_pkg::crf_out_t fe;
  logic [31:0] exp_q[$], msk_q[$];
  int n_fail = 0, n_compared = 0;
  initial
  begin
    forever #12.5 clk = !clk;
  end
  crf_fe_model fem_u (.clk(clk), .cold(cold), .tol_ok(tol_ok), .vflt(vflt), .shut(shut),
    .press(press), .temp_in_range(rng), .temp_in_tol(tol), .vin_fault(vin),
    .shut_fault(sht), .bypass_btn_n(btn_n));
  // Short counts keep the run brief; the waits below are fixed cycle counts sized to fit them, except the motor-stop poll of up to 1200 cycles.
  crf_mode_fsm #(.P_DWELL(36'h64), .P_INIT(24'ha), .P_RAMP(24'h4), .P_DEB(24'h4),
    .P_FLASH(25'h8)) dut_u (.clk(clk), .rst_n(rst_n), .temp_in_range(rng),
    .temp_in_tol(tol), .vin_fault(vin), .shut_fault(sht), .bypass_btn_n(btn_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .irq(irq), .fe(fe));
  task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (e & m))
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask : cmp
  task automatic fe_is(input logic [4:0] v, input logic [4:0] m);
    #1;
    cmp(32'({fe.bypass, fe.red_led, fe.grn_led, fe.alarm, fe.normal_mode}), 32'(v), 32'(m));
  endtask : fe_is
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
  task automatic st(input crf_pkg::crf_state_t s);
    rd(crf_pkg::REG_STATUS, 32'(s), 32'h7);
  endtask : st
  task automatic push_btn;
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    cyc(20);
  endtask : push_btn
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) rv <= rd_en;
  always @(negedge clk)
  begin
    if (rv && exp_q.size() > 0)
      cmp(rd_data, exp_q.pop_front(), msk_q.pop_front());
  end
  initial
  begin
    int k;
    k = $urandom(32'hb374);
    rnd = 8'($urandom());
    cyc(6);
    rst_n <= 1'b1;
    cyc(3);
    st(crf_pkg::ST_INIT);
    fe_is(5'h1c, 5'h1f);
    cmp(32'(fe.motor_drive), 32'h20, 32'hff);
    rd(crf_pkg::REG_CTRL, 32'h1, 32'h1);
    rd(crf_pkg::REG_DRIVE, 32'h0080ff20, 32'hffffff);
    rd(crf_pkg::REG_IRQ_EN, 32'h0, 32'hf);
    wr(8'h3c, $urandom());
    rd(8'h3c, 32'h0, 32'hffffffff);
    rd(crf_pkg::REG_IRQ_CLR, 32'h0, 32'hffffffff);
    wr(crf_pkg::REG_DRIVE, {8'h0, rnd, 8'hff, 8'h20});
    st(crf_pkg::ST_COOL);
    fe_is(5'h1c, 5'h1f);
    cmp(32'({fe.motor_drive, fe.lna_en}), 32'h1fe, 32'h1ff);
    cold <= 1'b1;
    tol_ok <= 1'b1;
    cyc(6);
    cmp(32'(fe.lna_en), 32'h1, 32'h1);
    cyc(50);
    tol_ok <= 1'b0;
    cyc(4);
    tol_ok <= 1'b1;
    cyc(90);
    st(crf_pkg::ST_COOL);
    cyc(20);
    st(crf_pkg::ST_REG);
    fe_is(5'h05, 5'h1f);
    rd(crf_pkg::REG_IRQ_ST, 32'h1, 32'h1);
    #1;
    cmp(32'(irq), 32'h0, 32'h1);
    wr(crf_pkg::REG_IRQ_EN, 32'h3);
    cyc(2);
    cmp(32'(irq), 32'h1, 32'h1);
    wr(crf_pkg::REG_IRQ_CLR, 32'hf);
    cyc(2);
    cmp(32'(irq), 32'h0, 32'h1);
    vflt <= 1'b1;
    cyc(6);
    st(crf_pkg::ST_VFLT);
    fe_is(5'h18, 5'h1f);
    cmp(32'({fe.motor_on, fe.motor_drive, irq}), {23'h1, rnd, 1'b1}, 32'h3ff);
    rd(crf_pkg::REG_IRQ_ST, 32'h2, 32'h2);
    wr(crf_pkg::REG_CTRL, 32'h0);
    vflt <= 1'b0;
    cyc(6);
    st(crf_pkg::ST_VFLT);
    wr(crf_pkg::REG_CTRL, 32'h1);
    cyc(2);
    st(crf_pkg::ST_REG);
    push_btn();
    st(crf_pkg::ST_FORCE);
    rd(crf_pkg::REG_IRQ_ST, 32'h8, 32'h8);
    fe_is(5'h12, 5'h1b);
    k = 0;
    g = fe.grn_led;
    repeat (20)
    begin
      cyc(1);
      if (fe.grn_led !== g)
        k++;
      g = fe.grn_led;
    end
    cmp(32'(k >= 2), 32'h1, 32'h1);
    shut <= 1'b1;
    cyc(8);
    st(crf_pkg::ST_FORCE);
    shut <= 1'b0;
    cyc(4);
    push_btn();
    st(crf_pkg::ST_REG);
    fe_is(5'h05, 5'h1f);
    shut <= 1'b1;
    cyc(6);
    st(crf_pkg::ST_SHUT);
    rd(crf_pkg::REG_IRQ_ST, 32'h4, 32'h4);
    fe_is(5'h18, 5'h1f);
    k = 0;
    while (fe.motor_on !== 1'b0 && k < 1200)
    begin
      cyc(1);
      k++;
    end
    if (k == 1200)
    begin
      n_fail++;
    end
    else
    begin
      cmp(32'(fe.motor_drive), 32'h0, 32'hff);
      shut <= 1'b0;
      cyc(8);
      st(crf_pkg::ST_SHUT);
      cold <= 1'b0;
      cyc(8);
      st(crf_pkg::ST_INIT);
      cyc(2);
    end
    give_verdict();
  end
endmodule : tb_crf_mode_fsm
